// ==== vco_serial_out_and_test_mux_tb_top.sv ====
// Purpose: self-checking bench for the vco serial output and test mux
// Assumes: apb answers after one access cycle; pins settle within a few cycles
// Notes: code 9 of the mux drives both aux pins, but only aux one is checked here
`timescale 1ns/1ps
module vco_serial_out_and_test_mux_tb_top;
    import vso_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [9:0] test_sig = 10'h000;
    logic locked_in = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, aux_pin_one, aux_pin_zero, aux_oe;
    logic lock_serial_pin, lock_serial_oe, irq;
    logic [9:0] vco_word, w;
    logic [1:0] t;
    int vco_bits, vco_words, n, n0, fail_count = 0, tests_run = 0, seed = 58686, sen_cyc = 0;
    int q_exp[$]; // words the vco should receive, oldest first
    vso_top i_vso_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_sig(test_sig), .locked_in(locked_in),
        .aux_pin_one(aux_pin_one), .aux_pin_zero(aux_pin_zero), .aux_oe(aux_oe),
        .lock_serial_pin(lock_serial_pin), .lock_serial_oe(lock_serial_oe), .irq(irq));
    vso_vco_model i_vso_vco_model (.sclk(aux_pin_one), .sen(aux_pin_zero),
        .sdata(lock_serial_pin), .word(vco_word), .bits(vco_bits), .words(vco_words));
    // ------------------------------------------------------------
    // clock, enable-width monitor, shared tasks
    // ------------------------------------------------------------
    always #25 pclk = ~pclk;
    // counts enable-high cycles so the serial rate shows up as a number
    always @(posedge pclk) if (aux_pin_zero === 1'b1) sen_cyc <= sen_cyc + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    // expected {aux one, aux zero} for a select code
    function automatic logic [1:0] mux_exp(input int c, input logic [9:0] s, input logic [1:0] v);
        case (c)
            0: return {s[0], s[1]};
            1: return {s[2], s[3]};
            2: return {s[4], s[5]};
            7: return {s[6], s[7]};
            8: return {s[8], s[9]};
            10: return v;
            default: return 2'b00;
        endcase
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(ADDR_VCO_WORD, 32'h0);
        rchk(ADDR_TEST_CTRL, 32'h0A);
        rchk(ADDR_LOCK_STATE, 32'h0);
        rchk(ADDR_CTRL, 32'h2);
        rchk(ADDR_IRQ_MASK, 32'h0);
        apb(1'b0, 10'h3FC, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h00000000);
        apb(1'b1, ADDR_LOCK_STATE, 32'h1);
        rchk(ADDR_LOCK_STATE, 32'h0);
        // every select code with random sources, pads enabled
        apb(1'b1, ADDR_CTRL, 32'h3);
        for (int c = 0; c < 16; c++) begin
            t = 2'($random(seed));
            test_sig <= 10'($random(seed));
            apb(1'b1, ADDR_TEST_CTRL, {26'h0, t, c[3:0]});
            cyc(6);
            if (c == 9) begin
                chk({aux_oe, aux_pin_one}, {1'b1, test_sig[6] | test_sig[7]});
            end else begin
                chk({aux_oe, aux_pin_one, aux_pin_zero},
                    {1'b1, mux_exp(c, test_sig, t)});
            end
        end
        apb(1'b1, ADDR_CTRL, 32'h2);
        cyc(3);
        chk(aux_oe, 1'b0);
        // lock flag, its pin gate and the lock interrupts
        apb(1'b1, ADDR_IRQ_MASK, 32'h6);
        locked_in <= 1'b1;
        cyc(8);
        rchk(ADDR_LOCK_STATE, 32'h1);
        chk({lock_serial_oe, lock_serial_pin, irq}, 3'b111);
        rchk(ADDR_IRQ_STAT, 32'h2);
        apb(1'b1, ADDR_IRQ_STAT, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        locked_in <= 1'b0;
        cyc(8);
        chk({lock_serial_oe, irq}, 2'b01);
        apb(1'b1, ADDR_IRQ_STAT, 32'h4);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        // with auto send off a word write only stores
        n0 = vco_words;
        apb(1'b1, ADDR_VCO_WORD, 32'h155);
        cyc(60);
        chk(vco_words, n0);
        rchk(ADDR_IRQ_STAT, 32'h0);
        // a send at each clock rate, with a second write while busy
        for (int q = 0; q < 2; q++) begin
            apb(1'b1, ADDR_TEST_CTRL, q ? 32'hC0 : 32'h80);
            cyc(4);
            n0 = vco_words;
            sen_cyc = 0;
            w = 10'($random(seed));
            q_exp.push_back(w);
            apb(1'b1, ADDR_VCO_WORD, {22'h0, w});
            cyc(6);
            chk({aux_oe, lock_serial_oe}, 2'b11);
            apb(1'b1, ADDR_VCO_WORD, {22'h0, ~w});
            n = 0;
            while (vco_words == n0 && n < 400) begin
                cyc(1);
                n++;
            end
            chk(vco_word, q_exp.pop_front());
            chk(vco_bits, 10);
            chk(sen_cyc, q ? 84 : 21);
            cyc(100);
            chk(vco_words, n0 + 1);
            rchk(ADDR_VCO_WORD, {22'h0, ~w});
            rchk(ADDR_IRQ_STAT, 32'h1);
            chk(irq, 1'b0);
            apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        end
        wrap_up();
    end
    // cut a hang short; the run needs well under a thousand cycles of the 20000 allowed
    initial begin
        #(50 * 20000);
        fail_count++;
        wrap_up();
    end
endmodule

// ==== vso_pkg.sv ====
// Purpose: constants for the vco serial output and test mux block
// Assumes: apb slave, 32-bit data, byte offsets are printed index times four
// Notes: one package shared by the single design file
package vso_pkg;
    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_VCO_WORD = 8'h0C;
    localparam logic [7:0] IDX_TEST_CTRL = 8'h0D;
    localparam logic [7:0] IDX_LOCK_STATE = 8'h0F;
    localparam logic [7:0] IDX_CTRL = 8'h10;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h11;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
    localparam logic [9:0] ADDR_VCO_WORD = {IDX_VCO_WORD, 2'b00};
    localparam logic [9:0] ADDR_TEST_CTRL = {IDX_TEST_CTRL, 2'b00};
    localparam logic [9:0] ADDR_LOCK_STATE = {IDX_LOCK_STATE, 2'b00};
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int VCO_WORD_W = 10;
    localparam int SEL_LSB = 0;
    localparam int TEST_LSB = 4;
    localparam int QUARTER_BIT = 6;
    localparam int AUTO_SEND_BIT = 7;
    localparam int PADS_EN_BIT = 0;
    localparam int LOCK_OE_BIT = 1;
    localparam logic [9:0] VCO_WORD_RST = 10'h000;
    localparam logic [7:0] TEST_CTRL_RST = 8'h0A;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [3:0] SEL_SW_TEST = 4'hA;
    localparam logic [1:0] QUARTER_DIV = 2'h3;
    localparam logic [3:0] BIT_CNT_LAST = 4'h9;
    // interrupt bits: send done, lock gained, lock lost
    localparam int IRQ_W = 3;
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_END} vso_state_t;
endpackage

// ==== vso_top.sv ====
// Purpose: vco serial word output, aux test mux and lock flag with apb access
// Assumes: internal test signals and lock come from async logic, so synced
// Notes: serial clock is generated as a divided strobe of pclk, not a clock
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module vso_top
    import vso_pkg::*;
(
    input wire logic pclk, // apb clock, 20 mhz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [9:0] test_sig, // internal test sources, async
    input wire logic locked_in, // lock detector, async
    output logic aux_pin_one, // aux pin one level
    output logic aux_pin_zero, // aux pin zero level
    output logic aux_oe, // aux pins output enable
    output logic lock_serial_pin, // lock flag or serial data
    output logic lock_serial_oe, // lock/serial pin output enable
    output logic irq // level interrupt
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [10:0] sync1_r;
    logic [10:0] sync2_r;
    // test_sig: 0 vco div,1 ref div,2 up,3 detector_down,4 ref,5 ref div out,
    // 6 slip add,7 slip sub,8 sat ref,9 sat vco
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {locked_in, test_sig};
            sync2_r <= sync1_r;
        end
    end
    logic locked_s;
    assign locked_s = sync2_r[10];
    // ------------------------------------------------------------
    // apb decode and registers
    // ------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic addr_hit;
    logic [9:0] vco_word_r;
    logic [7:0] test_ctrl_r;
    logic [1:0] ctrl_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic lock_flag_r;
    logic lock_prev_r;
    logic send_done;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    // word index compared at full width, so stray upper address bits never alias a register
    logic hit_word;
    logic hit_test;
    logic hit_lock;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    assign hit_word = (paddr[11:2] == {2'b00, IDX_VCO_WORD});
    assign hit_test = (paddr[11:2] == {2'b00, IDX_TEST_CTRL});
    assign hit_lock = (paddr[11:2] == {2'b00, IDX_LOCK_STATE});
    assign hit_ctrl = (paddr[11:2] == {2'b00, IDX_CTRL});
    assign hit_stat = (paddr[11:2] == {2'b00, IDX_IRQ_STAT});
    assign hit_mask = (paddr[11:2] == {2'b00, IDX_IRQ_MASK});
    assign addr_hit = hit_word || hit_test || hit_lock || hit_ctrl || hit_stat || hit_mask;
    logic wr_word;
    assign wr_word = wr_acc && hit_word;
    // writable registers; zero-wait slave so access phase completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_word_r <= VCO_WORD_RST;
            test_ctrl_r <= TEST_CTRL_RST;
            ctrl_r <= CTRL_RST;
            irq_mask_r <= '0;
        end else if (wr_acc) begin
            if (hit_word) vco_word_r <= pwdata[9:0];
            if (hit_test) test_ctrl_r <= pwdata[7:0];
            if (hit_ctrl) ctrl_r <= pwdata[1:0];
            if (hit_mask) irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end
    // lock flag register; read only, reset low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_flag_r <= 1'b0;
            lock_prev_r <= 1'b0;
        end else begin
            lock_flag_r <= locked_s;
            lock_prev_r <= lock_flag_r;
        end
    end
    // sticky status, set wins over write-one-to-clear
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_set = {lock_prev_r && !lock_flag_r, !lock_prev_r && lock_flag_r, send_done};
    assign irq_clr = (wr_acc && hit_stat) ?
                     pwdata[IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end
    // read data registered in setup phase, ready in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
            if (rd_acc) begin
                case (paddr[11:2])
                    {2'b00, IDX_VCO_WORD}: prdata <= {22'h000000, vco_word_r};
                    {2'b00, IDX_TEST_CTRL}: prdata <= {24'h000000, test_ctrl_r};
                    {2'b00, IDX_LOCK_STATE}: prdata <= {31'h00000000, lock_flag_r};
                    {2'b00, IDX_CTRL}: prdata <= {30'h00000000, ctrl_r};
                    {2'b00, IDX_IRQ_STAT}: prdata <= {29'h00000000, irq_stat_r};
                    {2'b00, IDX_IRQ_MASK}: prdata <= {29'h00000000, irq_mask_r};
                    default: prdata <= '0;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // vco serial sender
    // ------------------------------------------------------------
    logic auto_vco_send_en;
    logic serial_clk_quarter;
    assign auto_vco_send_en = test_ctrl_r[AUTO_SEND_BIT];
    assign serial_clk_quarter = test_ctrl_r[QUARTER_BIT];
    vso_state_t state_r;
    logic [1:0] div_r;
    logic [3:0] bit_cnt_r;
    logic [9:0] shift_r;
    logic sclk_r;
    logic sen_r;
    logic tick;
    // a half-period tick: every pclk, or every fourth for quarter rate
    assign tick = serial_clk_quarter ? (div_r == QUARTER_DIV) : 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else if (state_r == ST_IDLE || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign send_done = (state_r == ST_END) && tick;
    // msb first; data changes on falling sclk so the vco samples on rising
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= '0;
            shift_r <= '0;
            sclk_r <= 1'b0;
            sen_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (wr_word && auto_vco_send_en) begin
                        shift_r <= pwdata[9:0];
                        bit_cnt_r <= '0;
                        sen_r <= 1'b1;
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: if (tick) begin
                    sclk_r <= 1'b1;
                    state_r <= ST_HIGH;
                end
                ST_HIGH: if (tick) begin
                    sclk_r <= 1'b0;
                    if (bit_cnt_r == BIT_CNT_LAST) begin
                        state_r <= ST_END;
                    end else begin
                        shift_r <= {shift_r[8:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        state_r <= ST_LOW;
                    end
                end
                ST_END: if (tick) begin
                    sen_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // aux test mux and pin drive
    // ------------------------------------------------------------
    logic [1:0] mux_pair;
    always_comb begin
        case (test_ctrl_r[3:0])
            4'h0: mux_pair = {sync2_r[0], sync2_r[1]};
            4'h1: mux_pair = {sync2_r[2], sync2_r[3]};
            4'h2: mux_pair = {sync2_r[4], sync2_r[5]};
            4'h7: mux_pair = {sync2_r[6], sync2_r[7]};
            4'h8: mux_pair = {sync2_r[8], sync2_r[9]};
            4'h9: mux_pair = {sync2_r[6] | sync2_r[7], sync2_r[8] | sync2_r[9]};
            SEL_SW_TEST: mux_pair = {test_ctrl_r[5], test_ctrl_r[4]};
            default: mux_pair = 2'b00;
        endcase
    end
    // pins registered; auto send overrides the test mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_pin_one <= 1'b0;
            aux_pin_zero <= 1'b0;
            aux_oe <= 1'b0;
            lock_serial_pin <= 1'b0;
            lock_serial_oe <= 1'b0;
        end else begin
            if (auto_vco_send_en) begin
                aux_pin_one <= sclk_r;
                aux_pin_zero <= sen_r;
                aux_oe <= 1'b1;
                lock_serial_pin <= shift_r[9];
                lock_serial_oe <= 1'b1;
            end else begin
                aux_pin_one <= mux_pair[1];
                aux_pin_zero <= mux_pair[0];
                aux_oe <= ctrl_r[PADS_EN_BIT];
                lock_serial_pin <= lock_flag_r;
                lock_serial_oe <= ctrl_r[LOCK_OE_BIT];
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_send_starts: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && wr_word && auto_vco_send_en) |=> sen_r)
        else $error("send did not start on word write");
    a_no_send_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && wr_word && !auto_vco_send_en) |=> state_r == ST_IDLE)
        else $error("send started while disabled");
    a_sel_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> test_ctrl_r[3:0] == SEL_SW_TEST)
        else $error("select not ten after reset");
    a_pads_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!auto_vco_send_en && !ctrl_r[PADS_EN_BIT]) |=> !aux_oe)
        else $error("aux driven without pads enable");
    a_sw_test_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (!auto_vco_send_en && test_ctrl_r[3:0] == SEL_SW_TEST)
        |=> {aux_pin_one, aux_pin_zero} == $past(test_ctrl_r[5:4]))
        else $error("software test bits not on aux pins");
    a_unused_codes: assert property (@(posedge pclk) disable iff (!presetn)
        (!auto_vco_send_en && test_ctrl_r[3:0] > 4'hA) |=> !aux_pin_one && !aux_pin_zero)
        else $error("unused select code drove pins");
    a_quarter_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_clk_quarter && state_r != ST_IDLE && $rose(sclk_r))
        |-> (sclk_r && !auto_vco_send_en) or (sclk_r [*4]) or (state_r == ST_IDLE))
        else $error("quarter rate clock high too short");
    a_full_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (!serial_clk_quarter && state_r == ST_LOW) |=> state_r == ST_HIGH)
        else $error("full rate half period not one cycle");
    a_data_pin: assert property (@(posedge pclk) disable iff (!presetn)
        auto_vco_send_en |=> lock_serial_pin == $past(shift_r[9]) && lock_serial_oe)
        else $error("serial data not on shared pin");
    a_aux_serial: assert property (@(posedge pclk) disable iff (!presetn)
        auto_vco_send_en |=> aux_pin_one == $past(sclk_r) && aux_pin_zero == $past(sen_r))
        else $error("serial clock or enable not on aux pins");
    a_lock_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && hit_lock) |=> prdata == {31'h0, $past(lock_flag_r)})
        else $error("lock flag read wrong");
    a_lock_oe: assert property (@(posedge pclk) disable iff (!presetn)
        (!auto_vco_send_en && !ctrl_r[LOCK_OE_BIT]) |=> !lock_serial_oe)
        else $error("lock pin driven while disabled");
    a_enable_held: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_LOW || state_r == ST_HIGH) |-> sen_r)
        else $error("enable dropped mid transfer");
    a_enable_drops: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_END && tick) |=> !sen_r && state_r == ST_IDLE)
        else $error("enable not dropped after last bit");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !addr_hit) |=> pready && pslverr)
        else $error("unmapped address not flagged");
endmodule

// ==== vso_vco_model.sv ====
// Purpose: behavioural vco with a serial control input
// Assumes: clock, enable and data come from aux one, aux zero and the lock/serial pin
// Notes: passive listener; it never drives a line, so it has nothing to release
`timescale 1ns/1ps
module vso_vco_model (
    input wire logic sclk, // serial clock
    input wire logic sen, // serial enable
    input wire logic sdata, // serial data
    output logic [9:0] word, // last accepted word
    output int bits, // bits shifted into that word
    output int words // accepted word count
);
    logic [9:0] sh_r;
    int n_r;
    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    initial begin
        word = 10'h000;
        bits = 0;
        words = 0;
        sh_r = 10'h000;
        n_r = 0;
    end
    // sample on the rising clock only while enabled; msb lands first
    always @(posedge sclk) begin
        if (sen) begin
            sh_r <= {sh_r[8:0], sdata};
            n_r <= n_r + 1;
        end
    end
    // a fresh frame starts its bit count at zero, whatever the pins did before
    always @(posedge sen) begin
        n_r <= 0;
    end
    // the word counts only once enable falls, as a real part would
    always @(negedge sen) begin
        word <= sh_r;
        bits <= n_r;
        words <= words + 1;
        n_r <= 0;
    end
endmodule
